// file: mipr_cpu_model.sv
// cpu stand-in that pulses handler returns on request
// assumes the prioritizer on the same clock
module mipr_cpu_model (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // prioritizer side
  input  wire logic       pc_load_i,
  input  wire logic       busy_i,
  input  wire logic [2:0] active_i,
  input  wire logic       nmi_active_i,
  output logic            handler_ret_o,
  // bench side
  input  wire logic       ret_req_i
);
  logic pend_r;

  // return only from a running handler and never while busy
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pend_r        <= 1'b0;
      handler_ret_o <= 1'b0;
    end else begin
      handler_ret_o <= 1'b0;
      if (ret_req_i) begin
        pend_r <= 1'b1;
      end else if (pend_r && !busy_i && !pc_load_i && !handler_ret_o && (nmi_active_i || active_i != 3'h0)) begin
        pend_r        <= 1'b0;
        handler_ret_o <= 1'b1;
      end
    end
  end
endmodule

// file: mipr_properties.sv
// port checker of the prioritizer
// assumes it is bound onto mipr_top, one clock domain
module mipr_properties #(
  parameter int VEC_W = 16
) (
  // clock and reset
  input wire logic             REF_CLK_I,
  input wire logic             SRST_I,
  // inputs
  input wire logic             OSC_FAIL_I,
  input wire logic [2:0]       LEVEL_EN_I,
  input wire logic             VEC_BOOT_SEL_I,
  input wire logic [VEC_W-1:0] BOOT_BASE_I,
  input wire logic             GLOBAL_IE_I,
  input wire logic             HANDLER_RET_I,
  // outputs
  input wire logic             PC_LOAD_O,
  input wire logic [VEC_W-1:0] PC_VALUE_O,
  input wire logic [4:0]       ACK_SLOT_O,
  input wire logic             ACK_NMI_O,
  input wire logic [2:0]       ACTIVE_LEVEL_O,
  input wire logic             NMI_ACTIVE_O
);
  logic [2:0] act_q;
  logic [2:0] new_w;

  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (SRST_I);

  // previous active mask and freshly granted levels
  always_ff @(posedge REF_CLK_I) begin
    act_q <= ACTIVE_LEVEL_O;
  end
  assign new_w = ACTIVE_LEVEL_O & ~act_q;

  AST_RESET_VEC: assert property ($fell(SRST_I) |=> PC_LOAD_O &&
    PC_VALUE_O == ($past(VEC_BOOT_SEL_I) ? $past(BOOT_BASE_I) : '0)) else $error("reset vector wrong");
  AST_LOAD_PULSE: assert property (PC_LOAD_O |=> !PC_LOAD_O) else $error("load longer than one cycle");
  AST_HOLD: assert property (!PC_LOAD_O |-> $stable(PC_VALUE_O) && $stable(ACK_SLOT_O) && $stable(ACK_NMI_O))
    else $error("vector changed without load");
  AST_NMI_VEC: assert property (PC_LOAD_O && ACK_NMI_O |-> ACK_SLOT_O == 5'h0 &&
    PC_VALUE_O == ($past(VEC_BOOT_SEL_I) ? $past(BOOT_BASE_I) : '0) + 16'h0002) else $error("nmi vector wrong");
  AST_NMI_TAKEN: assert property (OSC_FAIL_I && !NMI_ACTIVE_O |-> ##[1:5] NMI_ACTIVE_O)
    else $error("nmi not taken");
  AST_NMI_LOAD: assert property ($rose(NMI_ACTIVE_O) |-> ##[1:2] (PC_LOAD_O && ACK_NMI_O))
    else $error("nmi grant without load");
  AST_GRANT_MASK: assert property (new_w != 3'h0 |-> $past(GLOBAL_IE_I) && !$past(NMI_ACTIVE_O) &&
    (new_w & ~$past(LEVEL_EN_I)) == 3'h0) else $error("masked level granted");
  AST_PREEMPT: assert property (new_w != 3'h0 |-> $countones(new_w) == 1 && new_w > act_q)
    else $error("grant not above active levels");
  AST_CLEAR_ON_RET: assert property ((act_q & ~ACTIVE_LEVEL_O) != 3'h0 |-> $past(HANDLER_RET_I))
    else $error("level cleared without return");
  AST_NMI_RET: assert property ($fell(NMI_ACTIVE_O) |-> $past(HANDLER_RET_I) && ACTIVE_LEVEL_O == act_q)
    else $error("nmi return wrong");
endmodule

bind mipr_top mipr_properties #(.VEC_W(VEC_W)) i_mipr_properties (
  .REF_CLK_I      (REF_CLK_I),
  .SRST_I         (SRST_I),
  .OSC_FAIL_I     (OSC_FAIL_I),
  .LEVEL_EN_I     (LEVEL_EN_I),
  .VEC_BOOT_SEL_I (VEC_BOOT_SEL_I),
  .BOOT_BASE_I    (BOOT_BASE_I),
  .GLOBAL_IE_I    (GLOBAL_IE_I),
  .HANDLER_RET_I  (HANDLER_RET_I),
  .PC_LOAD_O      (PC_LOAD_O),
  .PC_VALUE_O     (PC_VALUE_O),
  .ACK_SLOT_O     (ACK_SLOT_O),
  .ACK_NMI_O      (ACK_NMI_O),
  .ACTIVE_LEVEL_O (ACTIVE_LEVEL_O),
  .NMI_ACTIVE_O   (NMI_ACTIVE_O)
);

// file: mipr_tb_top.sv
// self-checking bench of the prioritizer
// assumes mipr_top, mipr_cpu_model and the bound checker
module mipr_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic         ref_clk = 1'b0;
  logic         srst = 1'b1;
  logic [21:0]  irq_req = '0;
  logic [43:0]  irq_level = '0;
  logic [109:0] irq_ofs = '0;
  logic         osc_fail = 1'b0;
  logic [2:0]   level_en = 3'h7;
  logic         rr_en = 1'b0;
  logic         boot_sel = 1'b0;
  logic [15:0]  boot_base = 16'h0000;
  logic         gie = 1'b1;
  logic         ret_req = 1'b0;
  logic         handler_ret, pc_load, ack_nmi, nmi_act, busy;
  logic [15:0]  pc_value;
  logic [4:0]   ack_slot, last_low;
  logic [2:0]   active;
  int           errors = 0;
  int           checks_done = 0;
  logic [15:0]  base_tbl [22] = '{16'h0004, 16'h0008,
    16'h0014, 16'h0018, 16'h001C, 16'h0028, 16'h0030, 16'h0032,
    16'h0038, 16'h0040, 16'h0044, 16'h0056, 16'h005A, 16'h005E,
    16'h0080, 16'h0084, 16'h0088, 16'h008E, 16'h009A, 16'h00AE, 16'h00B0, 16'h00FA};

  always #12.5 ref_clk = ~ref_clk;

  mipr_top i_mipr_top (.REF_CLK_I(ref_clk), .SRST_I(srst), .IRQ_REQ_I(irq_req), .IRQ_LEVEL_I(irq_level),
    .IRQ_OFFSET_I(irq_ofs), .OSC_FAIL_I(osc_fail), .LEVEL_EN_I(level_en), .RR_EN_I(rr_en),
    .VEC_BOOT_SEL_I(boot_sel), .BOOT_BASE_I(boot_base), .GLOBAL_IE_I(gie), .HANDLER_RET_I(handler_ret),
    .PC_LOAD_O(pc_load), .PC_VALUE_O(pc_value), .ACK_SLOT_O(ack_slot), .ACK_NMI_O(ack_nmi),
    .ACTIVE_LEVEL_O(active), .NMI_ACTIVE_O(nmi_act), .BUSY_O(busy), .LAST_LOW_O(last_low));

  mipr_cpu_model i_mipr_cpu_model (.clk_i(ref_clk), .srst_i(srst), .pc_load_i(pc_load), .busy_i(busy),
    .active_i(active), .nmi_active_i(nmi_act), .handler_ret_o(handler_ret), .ret_req_i(ret_req));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] sect();
    return boot_sel ? boot_base : 16'h0000;
  endfunction

  task automatic wait_load(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      @(negedge ref_clk);
      if (pc_load === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
  endtask

  // peripheral raises its line only once its level is configured
  task automatic req(input int s, input logic [1:0] l, input logic [4:0] o);
    irq_level[2*s+:2] = l;
    irq_ofs[5*s+:5]   = o;
    irq_req[s]        = 1'b1;
  endtask

  task automatic expect_vec(input int s, input logic [4:0] o, input bit keep);
    logic seen;
    wait_load(30, seen);
    chk("load", 16'h1, {15'h0, seen});
    chk("pc", sect() + base_tbl[s] + {11'h0, o}, pc_value);
    chk("slot", 16'(s + 1), {11'h0, ack_slot});
    chk("ack nmi", 16'h0, {15'h0, ack_nmi});
    chk("busy", 16'h0, {15'h0, busy});
    if (!keep) irq_req[s] = 1'b0;
  endtask

  task automatic do_ret();
    logic seen;
    seen = 1'b0;
    ret_req = 1'b1;
    @(negedge ref_clk);
    ret_req = 1'b0;
    repeat (10) begin
      @(negedge ref_clk);
      if (handler_ret === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    // the return lands at the next rising edge
    @(negedge ref_clk);
    chk("return", 16'h1, {15'h0, seen});
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic seen;
    int a, b;
    logic [1:0] lv;
    logic [4:0] of;
    int rr_slots [3] = '{0, 9, 21};
    void'($urandom(11));
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'b0;
    wait_load(2, seen);
    chk("reset load", 16'h1, {15'h0, seen});
    chk("reset pc", 16'h0000, pc_value);
    $display("test reset done");
    for (int s = 0; s < 22; s++) begin
      lv = 2'(1 + $urandom % 3);
      of = 5'($urandom % 2);
      req(s, lv, of);
      expect_vec(s, of, 1'b0);
      chk("active", 16'(1 << (lv - 1)), {13'h0, active});
      do_ret();
    end
    $display("test sweep done");
    a = $urandom % 21;
    b = a + 1 + $urandom % (21 - a);
    req(b, mipr_pkg::LVL_MED, 5'h0);
    req(a, mipr_pkg::LVL_MED, 5'h0);
    expect_vec(a, 5'h0, 1'b0);
    do_ret();
    expect_vec(b, 5'h0, 1'b0);
    do_ret();
    $display("test same level done");
    req(3, mipr_pkg::LVL_LOW, 5'h1);
    expect_vec(3, 5'h1, 1'b0);
    req(7, mipr_pkg::LVL_MED, 5'h0);
    expect_vec(7, 5'h0, 1'b0);
    req(1, mipr_pkg::LVL_LOW, 5'h0);
    req(12, mipr_pkg::LVL_HIGH, 5'h0);
    expect_vec(12, 5'h0, 1'b0);
    chk("active", 16'h0007, {13'h0, active});
    gie = 1'b0;
    osc_fail = 1'b1;
    wait_load(30, seen);
    chk("nmi pc", 16'h0002, pc_value);
    chk("nmi slot", 16'h0000, {11'h0, ack_slot});
    chk("nmi ack", 16'h1, {15'h0, ack_nmi});
    osc_fail = 1'b0;
    do_ret();
    gie = 1'b1;
    chk("after nmi", 16'h0007, {12'h0, nmi_act, active});
    do_ret();
    do_ret();
    wait_load(8, seen);
    chk("low blocked", 16'h0, {15'h0, seen});
    do_ret();
    expect_vec(1, 5'h0, 1'b0);
    do_ret();
    $display("test preempt done");
    level_en = 3'b101;
    gie = 1'b0;
    req(5, mipr_pkg::LVL_MED, 5'h0);
    wait_load(8, seen);
    chk("masked", 16'h0, {15'h0, seen});
    gie = 1'b1;
    wait_load(8, seen);
    chk("level off", 16'h0, {15'h0, seen});
    level_en = 3'h7;
    expect_vec(5, 5'h0, 1'b0);
    do_ret();
    $display("test mask done");
    srst = 1'b1;
    boot_sel = 1'b1;
    boot_base = 16'($urandom) & 16'h7F00;
    repeat (3) @(negedge ref_clk);
    chk("reset busy", 16'h1, {15'h0, busy});
    srst = 1'b0;
    wait_load(2, seen);
    chk("boot reset", boot_base, pc_value);
    rr_en = 1'b1;
    foreach (rr_slots[k]) req(rr_slots[k], mipr_pkg::LVL_LOW, 5'h0);
    for (int k = 0; k < 6; k++) begin
      expect_vec(rr_slots[k % 3], 5'h0, 1'b1);
      chk("last low", 16'(rr_slots[k % 3]), {11'h0, last_low});
      if (k == 5) irq_req = '0;
      do_ret();
    end
    rr_en = 1'b0;
    osc_fail = 1'b1;
    wait_load(30, seen);
    chk("boot nmi", boot_base + 16'h0002, pc_value);
    chk("boot nmi ack", 16'h1, {15'h0, ack_nmi});
    osc_fail = 1'b0;
    do_ret();
    $display("test boot and rotation done");
    results();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    results();
  end
endmodule

// file: mipr_top.sv
// multilevel interrupt prioritizer: arbitrates peripheral requests and steers the cpu program counter
// assumes requests, levels, offsets and cpu strobes come from logic on REF_CLK_I; no synchronisers

// What this block does
// - each source carries its own two-bit level: off, low, medium or high.
// - medium request preempts a running low-level handler.
// - high request preempts running medium or low handlers.
// - within a level the lowest vector, i.e. lowest source slot, wins.
// - low level offers selectable round-robin so every low source gets served.
// - oscillator failure is non-maskable and vectors to word 0x002.
// - on acknowledge the program counter is loaded with the granted vector.
// - vector equals peripheral base plus the interrupt's own offset.
// - all vectors and bases are program-memory word addresses.
// - reset vector word 0x000; port C base 0x004, port R 0x008.
// - real-time counter 0x014, two-wire C 0x018, first timer C 0x01C.
// - second timer C 0x028, SPI C vector 0x030, first serial C 0x032.
// - second serial C 0x038, nonvolatile controller 0x040, port B 0x044.
// - port E pins 0x056, two-wire E 0x05A, timer E 0x05E.
// - port D pins 0x080, port A pins 0x084, comparator A 0x088.
// - converter A 0x08E, timer D 0x09A, SPI D vector 0x0AE.
// - serial D base 0x0B0, USB base 0x0FA.
// - whole table relocates to application or boot section start by select.
module mipr_top #(
  parameter int NUM_SRC = 22,
  parameter int VEC_W   = 16,
  parameter int OFS_W   = 5
) (
  // clock and reset
  input  wire logic                     REF_CLK_I,
  input  wire logic                     SRST_I,
  // peripheral requests, slot i uses base table entry i+1
  input  wire logic [NUM_SRC-1:0]       IRQ_REQ_I,
  input  wire logic [2*NUM_SRC-1:0]     IRQ_LEVEL_I,
  input  wire logic [OFS_W*NUM_SRC-1:0] IRQ_OFFSET_I,
  input  wire logic                     OSC_FAIL_I,
  // configuration
  input  wire logic [2:0]               LEVEL_EN_I,
  input  wire logic                     RR_EN_I,
  input  wire logic                     VEC_BOOT_SEL_I,
  input  wire logic [VEC_W-1:0]         BOOT_BASE_I,
  // cpu side
  input  wire logic                     GLOBAL_IE_I,
  input  wire logic                     HANDLER_RET_I,
  output logic                          PC_LOAD_O,
  output logic [VEC_W-1:0]              PC_VALUE_O,
  // status
  output logic [4:0]                    ACK_SLOT_O,
  output logic                          ACK_NMI_O,
  output logic [2:0]                    ACTIVE_LEVEL_O,
  output logic                          NMI_ACTIVE_O,
  output logic                          BUSY_O,
  output logic [4:0]                    LAST_LOW_O
);
  localparam int IDX_W  = 5;
  localparam int SLOT_W = 5;

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (NUM_SRC != mipr_pkg::NUM_PERIPH) begin : g_chk_src
    $error("NUM_SRC must match the base vector table");
  end
  if (VEC_W < 9) begin : g_chk_vec
    $error("VEC_W too narrow for the vector table");
  end
  if (OFS_W < 1 || OFS_W >= VEC_W) begin : g_chk_ofs
    $error("OFS_W out of range");
  end

  typedef enum logic [1:0] {
    S_BOOT,
    S_IDLE,
    S_READ,
    S_LOAD
  } mipr_state_e;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // first set bit at or after start, wrapping; returns {found, index}
  function automatic logic [IDX_W:0] pick(input logic [NUM_SRC-1:0] m, input logic [IDX_W-1:0] start);
    logic [IDX_W:0] res;
    int             j;
    res = '0;
    j   = 0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      j = (int'(start) + i) % NUM_SRC;
      if (m[j]) begin
        res = {1'b1, IDX_W'(j)};
      end
    end
    return res;
  endfunction

  // word-address vector inside the selected section
  function automatic logic [VEC_W-1:0] vec_sum(input logic [VEC_W-1:0] sect, input logic [VEC_W-1:0] base,
                                               input logic [OFS_W-1:0] ofs);
    return VEC_W'(sect + base + VEC_W'(ofs));
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mipr_state_e        state_r;
  mipr_state_e        state_nxt;
  logic [SLOT_W-1:0]  sel_r;
  logic [OFS_W-1:0]   ofs_r;
  logic               sel_nmi_r;
  logic [2:0]         active_r;
  logic               nmi_act_r;
  logic [IDX_W-1:0]   last_low_r;
  logic               pc_load_r;
  logic [VEC_W-1:0]   pc_r;
  logic [VEC_W-1:0]   rom_base;

  // ---------------------------------------------------------------
  // request masks per level
  // ---------------------------------------------------------------
  logic [NUM_SRC-1:0] req_low;
  logic [NUM_SRC-1:0] req_med;
  logic [NUM_SRC-1:0] req_high;

  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      // requests arrive already gated by each peripheral's own enable
      req_low[i]  = IRQ_REQ_I[i] && IRQ_LEVEL_I[2*i +: 2] == mipr_pkg::LVL_LOW
                    && LEVEL_EN_I[mipr_pkg::LVL_BIT_LOW];
      req_med[i]  = IRQ_REQ_I[i] && IRQ_LEVEL_I[2*i +: 2] == mipr_pkg::LVL_MED
                    && LEVEL_EN_I[mipr_pkg::LVL_BIT_MED];
      req_high[i] = IRQ_REQ_I[i] && IRQ_LEVEL_I[2*i +: 2] == mipr_pkg::LVL_HIGH
                    && LEVEL_EN_I[mipr_pkg::LVL_BIT_HIGH];
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  logic [IDX_W:0]   pick_high;
  logic [IDX_W:0]   pick_med;
  logic [IDX_W:0]   pick_low;
  logic [IDX_W-1:0] low_start;
  logic             can_high;
  logic             can_med;
  logic             can_low;
  logic             nmi_pend;
  logic             arb_ok;

  always_comb begin
    // last served low source moves to the back of the queue
    if (RR_EN_I && int'(last_low_r) < NUM_SRC - 1) begin
      low_start = IDX_W'(last_low_r + IDX_W'(1));
    end else begin
      low_start = '0;
    end
    pick_high = pick(req_high, '0);
    pick_med  = pick(req_med, '0);
    pick_low  = pick(req_low, RR_EN_I ? low_start : IDX_W'(0));
    // only a strictly higher level may preempt
    can_high  = !active_r[mipr_pkg::LVL_BIT_HIGH];
    can_med   = !active_r[mipr_pkg::LVL_BIT_HIGH] && !active_r[mipr_pkg::LVL_BIT_MED];
    can_low   = active_r == 3'h0;
    nmi_pend  = OSC_FAIL_I && !nmi_act_r;
    arb_ok    = state_r == S_IDLE && !HANDLER_RET_I && !nmi_act_r;
  end

  logic             grant;
  logic             grant_nmi;
  logic [2:0]       grant_lvl;
  logic [IDX_W-1:0] grant_idx;

  always_comb begin
    grant     = 1'b0;
    grant_nmi = 1'b0;
    grant_lvl = 3'h0;
    grant_idx = '0;
    if (state_r == S_IDLE && !HANDLER_RET_I && nmi_pend) begin
      // non-maskable: ignores global enable and active levels
      grant     = 1'b1;
      grant_nmi = 1'b1;
    end else if (arb_ok && GLOBAL_IE_I && pick_high[IDX_W] && can_high) begin
      grant     = 1'b1;
      grant_lvl = 3'h4;
      grant_idx = pick_high[IDX_W-1:0];
    end else if (arb_ok && GLOBAL_IE_I && pick_med[IDX_W] && can_med) begin
      grant     = 1'b1;
      grant_lvl = 3'h2;
      grant_idx = pick_med[IDX_W-1:0];
    end else if (arb_ok && GLOBAL_IE_I && pick_low[IDX_W] && can_low) begin
      grant     = 1'b1;
      grant_lvl = 3'h1;
      grant_idx = pick_low[IDX_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_BOOT:  state_nxt = S_IDLE;
      S_IDLE:  state_nxt = grant ? S_READ : S_IDLE;
      S_READ:  state_nxt = S_LOAD;
      S_LOAD:  state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      state_r <= S_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // granted slot and offset, held for the table read
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      sel_r     <= '0;
      ofs_r     <= '0;
      sel_nmi_r <= 1'b0;
    end else if (grant) begin
      sel_nmi_r <= grant_nmi;
      if (grant_nmi) begin
        sel_r <= '0;
        ofs_r <= '0;
      end else begin
        sel_r <= SLOT_W'(grant_idx + IDX_W'(1));
        ofs_r <= IRQ_OFFSET_I[OFS_W*grant_idx +: OFS_W];
      end
    end
  end

  // ---------------------------------------------------------------
  // active handler tracking
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      active_r  <= 3'h0;
      nmi_act_r <= 1'b0;
    end else if (state_r == S_IDLE && HANDLER_RET_I) begin
      // return ends the innermost handler
      if (nmi_act_r) begin
        nmi_act_r <= 1'b0;
      end else if (active_r[mipr_pkg::LVL_BIT_HIGH]) begin
        active_r[mipr_pkg::LVL_BIT_HIGH] <= 1'b0;
      end else if (active_r[mipr_pkg::LVL_BIT_MED]) begin
        active_r[mipr_pkg::LVL_BIT_MED] <= 1'b0;
      end else begin
        active_r[mipr_pkg::LVL_BIT_LOW] <= 1'b0;
      end
    end else if (grant) begin
      nmi_act_r <= nmi_act_r | grant_nmi;
      active_r  <= active_r | grant_lvl;
    end
  end

  // round-robin pointer follows every low-level acknowledge
  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      last_low_r <= IDX_W'(NUM_SRC - 1);
    end else if (grant && grant_lvl == 3'h1) begin
      last_low_r <= grant_idx;
    end
  end

  // ---------------------------------------------------------------
  // base vector table
  // ---------------------------------------------------------------
  mipr_vec_rom #(
    .VEC_W  (VEC_W),
    .ADDR_W (SLOT_W)
  ) u_vec_rom (
    .clk_i  (REF_CLK_I),
    .srst_i (SRST_I),
    .addr_i (sel_r),
    .data_o (rom_base)
  );

  // ---------------------------------------------------------------
  // program counter steering
  // ---------------------------------------------------------------
  logic [VEC_W-1:0] sect_base;

  // table placed at application start (word 0) or boot section start
  assign sect_base = VEC_BOOT_SEL_I ? BOOT_BASE_I : VEC_W'(0);

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      pc_r      <= VEC_W'(mipr_pkg::RESET_VECTOR);
      pc_load_r <= 1'b0;
    end else if (state_r == S_BOOT) begin
      // reset vector issued once after release
      pc_r      <= vec_sum(sect_base, VEC_W'(mipr_pkg::RESET_VECTOR), '0);
      pc_load_r <= 1'b1;
    end else if (state_r == S_LOAD) begin
      pc_r      <= vec_sum(sect_base, rom_base, ofs_r);
      pc_load_r <= 1'b1;
    end else begin
      pc_load_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // status outputs
  // ---------------------------------------------------------------
  logic [SLOT_W-1:0] ack_slot_r;
  logic              ack_nmi_r;
  logic              busy_r;

  always_ff @(posedge REF_CLK_I) begin
    if (SRST_I) begin
      ack_slot_r <= '0;
      ack_nmi_r  <= 1'b0;
      busy_r     <= 1'b1;
    end else begin
      busy_r <= state_nxt != S_IDLE;
      if (state_r == S_LOAD) begin
        ack_slot_r <= sel_r;
        ack_nmi_r  <= sel_nmi_r;
      end
    end
  end

  assign PC_LOAD_O      = pc_load_r;
  assign PC_VALUE_O     = pc_r;
  assign ACK_SLOT_O     = ack_slot_r;
  assign ACK_NMI_O      = ack_nmi_r;
  assign ACTIVE_LEVEL_O = active_r;
  assign NMI_ACTIVE_O   = nmi_act_r;
  assign BUSY_O         = busy_r;
  assign LAST_LOW_O     = last_low_r;
endmodule

// file: mipr_vec_rom.sv
// shared constants of the multilevel interrupt prioritizer and its base-vector table
// assumes a single clock domain; the table read is registered, one cycle latency
package mipr_pkg;
  // program-memory word addresses of the fixed vectors
  localparam logic [15:0] RESET_VECTOR              = 16'h0000;
  localparam logic [15:0] OSC_FAIL_VECTOR           = 16'h0002;
  localparam logic [15:0] PORT_C_PIN_IRQ_BASE       = 16'h0004;
  localparam logic [15:0] PORT_R_PIN_IRQ_BASE       = 16'h0008;
  localparam logic [15:0] RTC_IRQ_BASE              = 16'h0014;
  localparam logic [15:0] TWO_WIRE_C_IRQ_BASE       = 16'h0018;
  localparam logic [15:0] TIMER_C_FIRST_IRQ_BASE    = 16'h001C;
  localparam logic [15:0] TIMER_C_SECOND_IRQ_BASE   = 16'h0028;
  localparam logic [15:0] SPI_C_VECTOR              = 16'h0030;
  localparam logic [15:0] SERIAL_C_FIRST_IRQ_BASE   = 16'h0032;
  localparam logic [15:0] SERIAL_C_SECOND_IRQ_BASE  = 16'h0038;
  localparam logic [15:0] NONVOLATILE_CTRL_IRQ_BASE = 16'h0040;
  localparam logic [15:0] PORT_B_PIN_IRQ_BASE       = 16'h0044;
  localparam logic [15:0] PORT_E_PIN_IRQ_BASE       = 16'h0056;
  localparam logic [15:0] TWO_WIRE_E_IRQ_BASE       = 16'h005A;
  localparam logic [15:0] TIMER_E_IRQ_BASE          = 16'h005E;
  localparam logic [15:0] PORT_D_PIN_IRQ_BASE       = 16'h0080;
  localparam logic [15:0] PORT_A_PIN_IRQ_BASE       = 16'h0084;
  localparam logic [15:0] COMPARATOR_A_IRQ_BASE     = 16'h0088;
  localparam logic [15:0] CONVERTER_A_IRQ_BASE      = 16'h008E;
  localparam logic [15:0] TIMER_D_IRQ_BASE          = 16'h009A;
  localparam logic [15:0] SPI_D_VECTOR              = 16'h00AE;
  localparam logic [15:0] SERIAL_D_IRQ_BASE         = 16'h00B0;
  localparam logic [15:0] USB_IRQ_BASE              = 16'h00FA;
  // peripheral sources, table slot 0 is the non-maskable source
  localparam int          NUM_PERIPH                = 22;
  localparam int          TABLE_DEPTH               = NUM_PERIPH + 1;
  // per-source level codes
  localparam logic [1:0]  LVL_OFF                   = 2'h0;
  localparam logic [1:0]  LVL_LOW                   = 2'h1;
  localparam logic [1:0]  LVL_MED                   = 2'h2;
  localparam logic [1:0]  LVL_HIGH                  = 2'h3;
  // bit positions in the level enable and active masks
  localparam int          LVL_BIT_LOW               = 0;
  localparam int          LVL_BIT_MED               = 1;
  localparam int          LVL_BIT_HIGH              = 2;
endpackage

module mipr_vec_rom #(
  parameter int VEC_W  = 16,
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              srst_i,
  // read port
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [VEC_W-1:0]  data_o
);
  logic [15:0] base;

  always_comb begin
    case (addr_i)
      ADDR_W'(0):  base = mipr_pkg::OSC_FAIL_VECTOR;
      ADDR_W'(1):  base = mipr_pkg::PORT_C_PIN_IRQ_BASE;
      ADDR_W'(2):  base = mipr_pkg::PORT_R_PIN_IRQ_BASE;
      ADDR_W'(3):  base = mipr_pkg::RTC_IRQ_BASE;
      ADDR_W'(4):  base = mipr_pkg::TWO_WIRE_C_IRQ_BASE;
      ADDR_W'(5):  base = mipr_pkg::TIMER_C_FIRST_IRQ_BASE;
      ADDR_W'(6):  base = mipr_pkg::TIMER_C_SECOND_IRQ_BASE;
      ADDR_W'(7):  base = mipr_pkg::SPI_C_VECTOR;
      ADDR_W'(8):  base = mipr_pkg::SERIAL_C_FIRST_IRQ_BASE;
      ADDR_W'(9):  base = mipr_pkg::SERIAL_C_SECOND_IRQ_BASE;
      ADDR_W'(10): base = mipr_pkg::NONVOLATILE_CTRL_IRQ_BASE;
      ADDR_W'(11): base = mipr_pkg::PORT_B_PIN_IRQ_BASE;
      ADDR_W'(12): base = mipr_pkg::PORT_E_PIN_IRQ_BASE;
      ADDR_W'(13): base = mipr_pkg::TWO_WIRE_E_IRQ_BASE;
      ADDR_W'(14): base = mipr_pkg::TIMER_E_IRQ_BASE;
      ADDR_W'(15): base = mipr_pkg::PORT_D_PIN_IRQ_BASE;
      ADDR_W'(16): base = mipr_pkg::PORT_A_PIN_IRQ_BASE;
      ADDR_W'(17): base = mipr_pkg::COMPARATOR_A_IRQ_BASE;
      ADDR_W'(18): base = mipr_pkg::CONVERTER_A_IRQ_BASE;
      ADDR_W'(19): base = mipr_pkg::TIMER_D_IRQ_BASE;
      ADDR_W'(20): base = mipr_pkg::SPI_D_VECTOR;
      ADDR_W'(21): base = mipr_pkg::SERIAL_D_IRQ_BASE;
      ADDR_W'(22): base = mipr_pkg::USB_IRQ_BASE;
      default:     base = mipr_pkg::RESET_VECTOR;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      data_o <= '0;
    end else begin
      data_o <= VEC_W'(base);
    end
  end
endmodule
